// ### rtl/microcore_wait_table_decode.sv
/*
 * Decode and execute of the register copy and the two wait-table entry
 * instructions, plus the five-row wait table and its concurrent evaluation.
 * Assumes a fetch stage presenting one word per instr_valid pulse, a
 * general register file with a registered one-cycle read port, and a wait
 * sequencer driving wait_active. All inputs are on ref_clk.
 */
`timescale 1ns/1ps

// Functional notes
// - Copy moves first operand into second operand
// - Copy word 101, src 12..8, dst 7..3, 000
// - Absolute entry 000100, jump reg, row, condition
// - Five rows; entry instructions overwrite selected row
// - All five rows evaluated concurrently
// - Enabled satisfied row redirects to its destination
// - Absolute row references jump register content
// - Relative destination is instruction address plus offset
// - Offset is 5-bit two's complement, -16..15
// - Codes 00-1f test flags low, then high
// - Terminal counts, start, shortcut feedback codes
// - ALU done and boost voltage codes
// - Current feedback high and low codes
// - Own current feedback high and low
// - Row operand 000..100 means rows 1..5
// - Relative entry 11, offset, row, condition
module microcore_wait_table_decode
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Instruction in
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic [9:0]  instr_addr,
    // General register file port
    input  wire logic [15:0] reg_rd_data,
    output logic [4:0]       reg_rd_sel_q,
    output logic             reg_wr_en_q,
    output logic [4:0]       reg_wr_sel_q,
    output logic [15:0]      reg_wr_data_q,
    // Jump registers
    input  wire logic [9:0]  jump_reg_zero,
    input  wire logic [9:0]  jump_reg_one,
    // Status for conditions
    input  wire logic [15:0] flags,
    input  wire logic [3:0]  term_count,
    input  wire logic        start_in,
    input  wire logic [2:0]  sc_drain_fbk,
    input  wire logic [2:0]  sc_source_fbk,
    input  wire logic        alu_done,
    input  wire logic        boost_voltage_high,
    input  wire logic [5:0]  cur_fbk,
    input  wire logic        own_cur_fbk,
    // Wait sequencing
    input  wire logic        wait_active,
    output logic             jump_req_q,
    output logic [9:0]       jump_addr_q,
    output logic [2:0]       jump_row_q,
    output logic [4:0]       row_valid_q
);

    // ********************************
    // Decode
    // ********************************
    logic        is_copy;
    logic        is_abs;
    logic        is_rel;
    logic [2:0]  instr_row;
    logic        row_in_range;
    logic        entry_wr;
    logic [4:0]  rel_offs;
    logic [9:0]  rel_target;

    assign is_copy = instr_valid && instr_word[15:13] == wait_table_pkg::COPY_OP
                     && instr_word[2:0] == wait_table_pkg::COPY_TAIL;
    assign is_abs = instr_valid && instr_word[15:10] == wait_table_pkg::ABS_ENTRY_OP;
    assign is_rel = instr_valid && instr_word[15:14] == wait_table_pkg::REL_ENTRY_OP;
    assign instr_row = instr_word[8:6];
    assign row_in_range = instr_row <= wait_table_pkg::LAST_ROW;
    assign entry_wr = (is_abs || is_rel) && row_in_range;
    assign rel_offs = instr_word[13:9];
    // Sign extension keeps backward jumps inside the code window
    assign rel_target = 10'(instr_addr + {{5{rel_offs[4]}}, rel_offs});

    // ********************************
    // Register copy, two stages
    // ********************************
    // Read port is registered, so the write lands two edges after issue
    logic       copy_pend_q;
    logic [4:0] copy_dst_q;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            copy_pend_q   <= 1'b0;
            copy_dst_q    <= 5'h00;
            reg_rd_sel_q  <= 5'h00;
            reg_wr_en_q   <= 1'b0;
            reg_wr_sel_q  <= 5'h00;
            reg_wr_data_q <= 16'h0000;
        end
        else
        begin
            copy_pend_q <= is_copy;
            if (is_copy)
            begin
                reg_rd_sel_q <= instr_word[12:8];
                copy_dst_q   <= instr_word[7:3];
            end
            reg_wr_en_q <= copy_pend_q;
            if (copy_pend_q)
            begin
                reg_wr_sel_q  <= copy_dst_q;
                reg_wr_data_q <= reg_rd_data;
            end
        end
    end

    // ********************************
    // Wait table rows
    // ********************************
    logic [5:0] row_cond_q [5];
    logic       row_rel_q  [5];
    logic       row_jreg_q [5];
    logic [9:0] row_dest_q [5];
    logic [9:0] row_addr   [5];
    logic [4:0] cond_met;
    logic [4:0] hit_vec;

    genvar r;
    generate
        for (r = 0; r < 5; r++)
        begin : g_row
            logic sel_row;
            assign sel_row = entry_wr && instr_row == 3'(r);

            always_ff @(posedge ref_clk)
            begin
                if (srst)
                begin
                    row_valid_q[r] <= 1'b0;
                    row_cond_q[r]  <= 6'h00;
                    row_rel_q[r]   <= 1'b0;
                    row_jreg_q[r]  <= 1'b0;
                    row_dest_q[r]  <= 10'h000;
                end
                else if (sel_row)
                begin
                    row_valid_q[r] <= 1'b1;
                    row_cond_q[r]  <= instr_word[5:0];
                    row_rel_q[r]   <= is_rel;
                    row_jreg_q[r]  <= instr_word[9];
                    row_dest_q[r]  <= rel_target;
                end
            end

            // Absolute rows read the jump register live, at wait time
            assign row_addr[r] = row_rel_q[r] ? row_dest_q[r]
                                 : (row_jreg_q[r] ? jump_reg_one : jump_reg_zero);

            wait_cond_select u_cond
            (
                .cond_code          (row_cond_q[r]),
                .flags              (flags),
                .term_count         (term_count),
                .start_in           (start_in),
                .sc_drain_fbk       (sc_drain_fbk),
                .sc_source_fbk      (sc_source_fbk),
                .alu_done           (alu_done),
                .boost_voltage_high (boost_voltage_high),
                .cur_fbk            (cur_fbk),
                .own_cur_fbk        (own_cur_fbk),
                .cond_met           (cond_met[r])
            );

            assign hit_vec[r] = row_valid_q[r] && cond_met[r];
        end
    endgenerate

    // ********************************
    // Priority select
    // ********************************
    logic       any_hit;
    logic [2:0] hit_row;
    logic [9:0] hit_addr;

    always_comb
    begin
        hit_row = 3'h0;
        for (int i = 4; i >= 0; i--)
        begin
            if (hit_vec[i])
                hit_row = 3'(i);
        end
    end

    assign any_hit = wait_active && hit_vec != wait_table_pkg::ROW_EMPTY;
    assign hit_addr = row_addr[hit_row];

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            jump_req_q  <= 1'b0;
            jump_addr_q <= 10'h000;
            jump_row_q  <= 3'h0;
        end
        else
        begin
            jump_req_q <= any_hit;
            if (any_hit)
            begin
                jump_addr_q <= hit_addr;
                jump_row_q  <= hit_row;
            end
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    AST_COPY_READ: assert property (is_copy |=> reg_rd_sel_q == $past(instr_word[12:8]))
        else $error("copy source select wrong");
    AST_COPY_WRITE: assert property (is_copy |=> ##1 reg_wr_en_q && reg_wr_data_q == $past(reg_rd_data)
                                     && reg_wr_sel_q == $past(instr_word[7:3], 2))
        else $error("copy write wrong");
    AST_ABS_ENTRY: assert property (is_abs && row_in_range |=> row_valid_q[$past(instr_row)]
                                    && !row_rel_q[$past(instr_row)]
                                    && row_cond_q[$past(instr_row)] == $past(instr_word[5:0]))
        else $error("absolute entry not stored");
    AST_REL_DEST: assert property (is_rel && row_in_range |=> row_rel_q[$past(instr_row)]
                                   && row_dest_q[$past(instr_row)] == $past(rel_target))
        else $error("relative destination not stored");
    AST_REL_BACK: assert property (is_rel && rel_offs[4] |-> 10'(instr_addr - rel_target) <= 10'h010
                                   && rel_target != instr_addr)
        else $error("negative offset not sign extended");
    AST_ROW_RANGE: assert property (instr_valid && !row_in_range && !is_copy
                                    |=> row_valid_q == $past(row_valid_q))
        else $error("out of range row written");
    AST_JUMP: assert property (any_hit |=> jump_req_q && jump_addr_q == $past(hit_addr))
        else $error("jump not taken");
    AST_NO_JUMP: assert property (!wait_active |=> !jump_req_q)
        else $error("jump outside wait");
    AST_LOWEST: assert property (wait_active && hit_vec[0] |=> jump_row_q == 3'h0)
        else $error("lower row not preferred");
    AST_CONCUR: assert property (wait_active && hit_vec == 5'h10 |=> jump_row_q == 3'h4)
        else $error("row five not monitored");
    AST_ABS_ADDR: assert property (wait_active && hit_vec[0] && !row_rel_q[0] && row_jreg_q[0]
                                   |=> jump_addr_q == $past(jump_reg_one))
        else $error("absolute jump address wrong");
    AST_FLAG_LOW: assert property (row_cond_q[0] < 6'h10 |-> cond_met[0] == !flags[row_cond_q[0][3:0]])
        else $error("flag low decode wrong");
    AST_OWN: assert property (row_cond_q[1] == 6'h3f |-> cond_met[1] == !own_cur_fbk)
        else $error("own current low decode wrong");
    AST_RESET_EMPTY: assert property (@(posedge ref_clk) $past(srst) |-> row_valid_q == 5'h00
                                      && !jump_req_q)
        else $error("rows not empty after reset");

    COV_COPY: cover property (is_copy ##2 reg_wr_en_q);
    COV_REL_JUMP: cover property (wait_active && hit_vec[2] && row_rel_q[2] ##1 jump_req_q);
    COV_MULTI_HIT: cover property (wait_active && hit_vec[0] && hit_vec[4]);
    COV_OVERWRITE: cover property (entry_wr && row_valid_q[instr_row]);

endmodule

// ### shared/wait_table_pkg.sv
/*
 * Constants for the microcore copy and wait-table decode block.
 * Assumes 16-bit microcode words and a single clock domain.
 */
package wait_table_pkg;

    // ********************************
    // Widths and table size
    // ********************************
    localparam int ADDR_W   = 10;
    localparam int DATA_W   = 16;
    localparam int ROWS     = 5;
    localparam int COND_W   = 6;
    localparam int GREG_W   = 5;
    localparam int ROW_W    = 3;
    localparam int OFFS_W   = 5;

    // ********************************
    // Opcode fields
    // ********************************
    localparam logic [2:0] COPY_OP      = 3'h5;
    localparam logic [2:0] COPY_TAIL    = 3'h0;
    localparam logic [5:0] ABS_ENTRY_OP = 6'h04;
    localparam logic [1:0] REL_ENTRY_OP = 2'h3;
    localparam logic [2:0] LAST_ROW     = 3'h4;
    localparam logic [4:0] ROW_EMPTY    = 5'h00;

    // ********************************
    // Condition codes
    // ********************************
    localparam logic [5:0] C_FLAG_HI    = 6'h10;
    localparam logic [5:0] C_TERM_CNT   = 6'h20;
    localparam logic [5:0] C_START_LO   = 6'h24;
    localparam logic [5:0] C_START_HI   = 6'h25;
    localparam logic [5:0] C_DRAIN1_LO  = 6'h26;
    localparam logic [5:0] C_DRAIN2_LO  = 6'h27;
    localparam logic [5:0] C_DRAIN3_LO  = 6'h28;
    localparam logic [5:0] C_SOURCE1_LO = 6'h29;
    localparam logic [5:0] C_SOURCE2_LO = 6'h2a;
    localparam logic [5:0] C_SOURCE3_LO = 6'h2b;
    localparam logic [5:0] C_DRAIN1_HI  = 6'h2c;
    localparam logic [5:0] C_DRAIN2_HI  = 6'h2d;
    localparam logic [5:0] C_DRAIN3_HI  = 6'h2e;
    localparam logic [5:0] C_ALU_DONE   = 6'h2f;
    localparam logic [5:0] C_BOOST_HI   = 6'h30;
    localparam logic [5:0] C_BOOST_LO   = 6'h31;
    localparam logic [5:0] C_CUR_HI     = 6'h32;
    localparam logic [5:0] C_CUR_LO     = 6'h38;
    localparam logic [5:0] C_OWN_HI     = 6'h3e;
    localparam logic [5:0] C_OWN_LO     = 6'h3f;
    localparam logic [2:0] CUR_HI_BASE  = 3'h2;

endpackage

// ### rtl/wait_cond_select.sv
/*
 * Evaluates one 6-bit wait condition code against the live status inputs.
 * Purely combinational; all inputs are on the core clock already.
 */
`timescale 1ns/1ps

module wait_cond_select
(
    // Condition under test
    input  wire logic [5:0]  cond_code,
    // Live status
    input  wire logic [15:0] flags,
    input  wire logic [3:0]  term_count,
    input  wire logic        start_in,
    input  wire logic [2:0]  sc_drain_fbk,
    input  wire logic [2:0]  sc_source_fbk,
    input  wire logic        alu_done,
    input  wire logic        boost_voltage_high,
    input  wire logic [5:0]  cur_fbk,
    input  wire logic        own_cur_fbk,
    // Result
    output logic             cond_met
);

    logic [2:0] cur_hi_idx;
    logic [2:0] cur_lo_idx;

    assign cur_hi_idx = cond_code[2:0] - wait_table_pkg::CUR_HI_BASE;
    assign cur_lo_idx = cond_code[2:0];

    always_comb
    begin
        cond_met = 1'b0;
        if (cond_code < wait_table_pkg::C_FLAG_HI)
            cond_met = ~flags[cond_code[3:0]];
        else if (cond_code < wait_table_pkg::C_TERM_CNT)
            cond_met = flags[cond_code[3:0]];
        else if (cond_code < wait_table_pkg::C_START_LO)
            cond_met = term_count[cond_code[1:0]];
        else if (cond_code >= wait_table_pkg::C_CUR_LO && cond_code < wait_table_pkg::C_OWN_HI)
            cond_met = ~cur_fbk[cur_lo_idx];
        else if (cond_code >= wait_table_pkg::C_CUR_HI && cond_code < wait_table_pkg::C_CUR_LO)
            cond_met = cur_fbk[cur_hi_idx];
        else
        begin
            case (cond_code)
                wait_table_pkg::C_START_LO: cond_met = ~start_in;
                wait_table_pkg::C_START_HI: cond_met = start_in;
                wait_table_pkg::C_DRAIN1_LO:  cond_met = ~sc_drain_fbk[0];
                wait_table_pkg::C_DRAIN2_LO:  cond_met = ~sc_drain_fbk[1];
                wait_table_pkg::C_DRAIN3_LO:  cond_met = ~sc_drain_fbk[2];
                wait_table_pkg::C_SOURCE1_LO: cond_met = ~sc_source_fbk[0];
                wait_table_pkg::C_SOURCE2_LO: cond_met = ~sc_source_fbk[1];
                wait_table_pkg::C_SOURCE3_LO: cond_met = ~sc_source_fbk[2];
                wait_table_pkg::C_DRAIN1_HI:  cond_met = sc_drain_fbk[0];
                wait_table_pkg::C_DRAIN2_HI:  cond_met = sc_drain_fbk[1];
                wait_table_pkg::C_DRAIN3_HI:  cond_met = sc_drain_fbk[2];
                wait_table_pkg::C_ALU_DONE: cond_met = alu_done;
                wait_table_pkg::C_BOOST_HI: cond_met = boost_voltage_high;
                wait_table_pkg::C_BOOST_LO: cond_met = ~boost_voltage_high;
                wait_table_pkg::C_OWN_HI:   cond_met = own_cur_fbk;
                wait_table_pkg::C_OWN_LO:   cond_met = ~own_cur_fbk;
                default:                    cond_met = 1'b0;
            endcase
        end
    end

endmodule

// ### tb/tb_microcore_wait_table_decode.sv
/*
 * Self-checking bench for the copy and wait-table decode block.
 * Assumes the design package is compiled first; the bench plays fetch,
 * register file, jump registers, status lines and wait sequencer.
 */
`timescale 1ns/1ps

module tb_microcore_wait_table_decode;

    // ************************************
    // Stimulus and observed signals
    // ************************************
    logic        ref_clk       = 1'b0;
    logic        srst          = 1'b1;
    logic        instr_valid   = 1'b0;
    logic [15:0] instr_word    = 16'h0000;
    logic [9:0]  instr_addr    = 10'h000;
    logic [15:0] reg_rd_data   = 16'h0000;
    logic [9:0]  jump_reg_zero = 10'h2a5;
    logic [9:0]  jump_reg_one  = 10'h15a;
    logic [35:0] status        = 36'h000000000;
    logic        wait_active   = 1'b0;
    logic [4:0]  reg_rd_sel_q;
    logic        reg_wr_en_q;
    logic [4:0]  reg_wr_sel_q;
    logic [15:0] reg_wr_data_q;
    logic        jump_req_q;
    logic [9:0]  jump_addr_q;
    logic [2:0]  jump_row_q;
    logic [4:0]  row_valid_q;
    logic [26:0] cp1_q         = 27'h0;
    logic [26:0] cp2_q         = 27'h0;
    logic        started       = 1'b0;
    wire  logic  copy_hit;
    int          bad_count     = 0;
    int          total_checks  = 0;
    int          cycles        = 0;
    logic [35:0] pats [4]      = '{36'h000000000, 36'hfffffffff, 36'h555555555, 36'haaaaaaaaa};

    always #10 ref_clk = ~ref_clk;

    microcore_wait_table_decode dut
    (
        .ref_clk            (ref_clk),
        .srst               (srst),
        .instr_valid        (instr_valid),
        .instr_word         (instr_word),
        .instr_addr         (instr_addr),
        .reg_rd_data        (reg_rd_data),
        .reg_rd_sel_q       (reg_rd_sel_q),
        .reg_wr_en_q        (reg_wr_en_q),
        .reg_wr_sel_q       (reg_wr_sel_q),
        .reg_wr_data_q      (reg_wr_data_q),
        .jump_reg_zero      (jump_reg_zero),
        .jump_reg_one       (jump_reg_one),
        .flags              (status[35:20]),
        .term_count         (status[19:16]),
        .start_in           (status[15]),
        .sc_drain_fbk       (status[14:12]),
        .sc_source_fbk      (status[11:9]),
        .alu_done           (status[8]),
        .boost_voltage_high (status[7]),
        .cur_fbk            (status[6:1]),
        .own_cur_fbk        (status[0]),
        .wait_active        (wait_active),
        .jump_req_q         (jump_req_q),
        .jump_addr_q        (jump_addr_q),
        .jump_row_q         (jump_row_q),
        .row_valid_q        (row_valid_q)
    );

    // ************************************
    // Helpers
    // ************************************
    function automatic logic [15:0] rd_val(input logic [4:0] s);
        return {s, ~s, s, 1'b1};
    endfunction

    function automatic logic [15:0] copy_w(input logic [4:0] s, input logic [4:0] d);
        return {3'b101, s, d, 3'b000};
    endfunction

    function automatic logic [15:0] abs_w(input logic j, input logic [2:0] r, input logic [5:0] c);
        return {6'b000100, j, r, c};
    endfunction

    function automatic logic [15:0] rel_w(input logic [4:0] o, input logic [2:0] r, input logic [5:0] c);
        return {2'b11, o, r, c};
    endfunction

    // Expected truth of a condition code for a packed status vector
    function automatic logic cond_exp(input logic [5:0] c, input logic [35:0] s);
        int i;
        i = int'(c);
        if (i < 16) return !s[20 + i];
        if (i < 32) return s[i + 4];
        if (i < 36) return s[i - 16];
        if (i == 36) return !s[15];
        if (i == 37) return s[15];
        if (i < 41) return !s[i - 26];
        if (i < 44) return !s[i - 32];
        if (i < 47) return s[i - 32];
        if (i == 47) return s[8];
        if (i == 48) return s[7];
        if (i == 49) return !s[7];
        if (i < 56) return s[i - 49];
        if (i < 62) return !s[i - 55];
        if (i == 62) return s[0];
        return !s[0];
    endfunction

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic put(input logic [15:0] w, input logic [9:0] a);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_word  <= w;
        instr_addr  <= a;
    endtask

    task automatic idle();
        @(posedge ref_clk);
        instr_valid <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] w, input logic [9:0] a);
        put(w, a);
        idle();
    endtask

    task automatic eval(input logic act, input logic [35:0] st, input logic hit, input logic [9:0] addr,
                        input logic [2:0] row);
        @(posedge ref_clk);
        status      <= st;
        wait_active <= act;
        @(posedge ref_clk);
        wait_active <= 1'b0;
        #1;
        chk("jump_req_q", {15'h0, hit}, {15'h0, jump_req_q});
        if (hit)
        begin
            chk("jump_addr_q", {6'h0, addr}, {6'h0, jump_addr_q});
            chk("jump_row_q", {13'h0, row}, {13'h0, jump_row_q});
        end
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ************************************
    // Register file read port and copy watch
    // ************************************
    assign copy_hit = instr_valid && (instr_word[15:13] == 3'b101) && (instr_word[2:0] == 3'b000);

    // Read data appears in the cycle after the copy is taken
    always @(posedge ref_clk)
    begin
        if (instr_valid)
            reg_rd_data <= rd_val(instr_word[12:8]);
        cp1_q <= srst ? 27'h0 : {copy_hit, instr_word[12:8], instr_word[7:3], rd_val(instr_word[12:8])};
        cp2_q <= srst ? 27'h0 : cp1_q;
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            $display("[ERR] run_length expected end seen hang");
            summarize();
        end
    end

    always @(negedge ref_clk)
    begin
        if (!srst && started)
        begin
            chk("reg_wr_en_q", {15'h0, cp2_q[26]}, {15'h0, reg_wr_en_q});
            if (cp1_q[26])
                chk("reg_rd_sel_q", {11'h0, cp1_q[25:21]}, {11'h0, reg_rd_sel_q});
            if (cp2_q[26])
            begin
                chk("reg_wr_sel_q", {11'h0, cp2_q[20:16]}, {11'h0, reg_wr_sel_q});
                chk("reg_wr_data_q", cp2_q[15:0], reg_wr_data_q);
            end
        end
    end

    // ************************************
    // Main sequence
    // ************************************
    initial
    begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("row_valid_q", 16'h0, {11'h0, row_valid_q});
        chk("jump_req_q", 16'h0, {15'h0, jump_req_q});
        chk("jump_addr_q", 16'h0, {6'h0, jump_addr_q});
        started = 1'b1;
        $display("test reset done");
        // Every condition code against each status pattern
        for (int c = 0; c < 64; c++)
        begin
            wr(abs_w(c[0], 3'h0, c[5:0]), 10'h000);
            for (int p = 0; p < 4; p++)
                eval(1'b1, pats[p], cond_exp(c[5:0], pats[p]), c[0] ? jump_reg_one : jump_reg_zero, 3'h0);
        end
        chk("row_valid_q", 16'h1, {11'h0, row_valid_q});
        $display("test conditions done");
        // Back-to-back copies, then words the copy path must ignore
        put(copy_w(5'h1f, 5'h00), 10'h010);
        put(copy_w(5'h00, 5'h1f), 10'h011);
        put(copy_w(5'h0a, 5'h15) | 16'h0001, 10'h012);
        put(16'h8a50, 10'h013);
        idle();
        repeat (3) @(posedge ref_clk);
        $display("test copy done");
        // Mid-run reset empties the table
        @(posedge ref_clk);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk("row_valid_q", 16'h0, {11'h0, row_valid_q});
        eval(1'b1, 36'hfffffffff, 1'b0, 10'h000, 3'h0);
        $display("test second reset done");
        // Relative rows at both offset limits, with address wrap
        wr(rel_w(5'h10, 3'h1, 6'h25), 10'h005);
        eval(1'b1, 36'h000008000, 1'b1, 10'h3f5, 3'h1);
        wr(rel_w(5'h0f, 3'h1, 6'h25), 10'h3fa);
        eval(1'b1, 36'h000008000, 1'b1, 10'h009, 3'h1);
        chk("row_valid_q", 16'h2, {11'h0, row_valid_q});
        $display("test relative done");
        // Full table, refused row, concurrency and priority
        wr(abs_w(1'b1, 3'h4, 6'h30), 10'h000);
        wr(abs_w(1'b0, 3'h3, 6'h2f), 10'h000);
        wr(rel_w(5'h01, 3'h0, 6'h0f), 10'h100);
        wr(abs_w(1'b0, 3'h2, 6'h3e), 10'h000);
        wr(abs_w(1'b0, 3'h5, 6'h00), 10'h000);
        chk("row_valid_q", 16'h1f, {11'h0, row_valid_q});
        eval(1'b1, 36'h800000000, 1'b0, 10'h000, 3'h0);
        eval(1'b1, 36'h800000080, 1'b1, jump_reg_one, 3'h4);
        eval(1'b1, 36'h800000180, 1'b1, jump_reg_zero, 3'h3);
        eval(1'b1, 36'h7ffffffff, 1'b1, 10'h101, 3'h0);
        @(posedge ref_clk);
        jump_reg_one <= 10'h3c3;
        eval(1'b1, 36'h800000080, 1'b1, 10'h3c3, 3'h4);
        eval(1'b0, 36'h7ffffffff, 1'b0, 10'h000, 3'h0);
        $display("test table done");
        summarize();
    end

endmodule
